// ===== inc/bcrcg_pkg.sv
package bcrcg_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CRC_CTRL = 8'h00;
	localparam logic [7:0] OFF_CRC_STATUS = 8'h01;
	localparam logic [7:0] OFF_CRC_BYTE_INPUT = 8'h03;
	localparam logic [7:0] OFF_CHECKSUM0 = 8'h04;
	localparam logic [7:0] OFF_CHECKSUM3 = 8'h07;
	localparam logic [7:0] OFF_MEMCTL_CMD = 8'h08;
	localparam logic [7:0] OFF_MEMCTL_CONTROL_A = 8'h09;
	localparam logic [7:0] OFF_MEMCTL_STATUS = 8'h0a;
	localparam logic [7:0] OFF_RANGE_START_L = 8'h0b;
	localparam logic [7:0] OFF_RANGE_START_H = 8'h0c;
	localparam logic [7:0] OFF_RANGE_END_L = 8'h0d;
	localparam logic [7:0] OFF_RANGE_END_H = 8'h0e;
	localparam logic [7:0] OFF_MEMCTL_DATA0 = 8'h10;
	localparam logic [7:0] OFF_MEMCTL_DATA3 = 8'h13;
	localparam logic [7:0] OFF_LINK_STATUS = 8'h14;
	localparam logic [7:0] OFF_CHANGE_PROTECT_UNLOCK = 8'h15;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_POLY32_BIT = 5;
	localparam int CTRL_CLEAR_BIT = 7;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int CONTROL_A_EXEC_BIT = 0;
	localparam int MEMCTL_BUSY_BIT = 7;
	localparam int LINK_PATH_EN_BIT = 1;

	// ----------------------------------------
	// sources, commands, constants
	// ----------------------------------------
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_IO = 2'h1;
	localparam logic [1:0] SRC_FLASH = 2'h2;

	localparam logic [7:0] CMD_APP_CRC = 8'h38;
	localparam logic [7:0] CMD_BOOT_CRC = 8'h39;
	localparam logic [7:0] CMD_RANGE_CRC = 8'h3a;
	localparam logic [7:0] CMD_FLASH_CRC = 8'h78;

	localparam logic [7:0] UNLOCK_KEY = 8'hd8;
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

	localparam logic [31:0] POLY32 = 32'h04c11db7;
	localparam logic [15:0] POLY16 = 16'h1021;
	localparam logic [31:0] INIT32 = 32'hffffffff;
	localparam logic [31:0] INIT16 = 32'h0000ffff;

	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CMD = 8'h00;
	localparam logic [15:0] RST_RANGE = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_LAST = 2'b10,
		ST_DONE = 2'b11
	} bcrcg_state_e;
endpackage : bcrcg_pkg

// ===== logic/bcrcg_step.sv
module bcrcg_step (
	// running value and byte
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data,
	input wire logic use32,
	// updated value
	output logic [31:0] crc_out
);
	logic [31:0] stage [0:8];

	assign stage[0] = use32 ? crc_in : {16'h0000, crc_in[15:0]};

	// ----------------------------------------
	// one shift per bit, whole bytes only
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			logic fb32;
			logic fb16;
			logic [31:0] n32;
			logic [15:0] n16;
			// 32-bit path takes the byte lsb first (reflected input)
			assign fb32 = stage[i][31] ^ data[i];
			assign fb16 = stage[i][15] ^ data[7 - i];
			assign n32 = {stage[i][30:0], 1'b0} ^ (fb32 ? bcrcg_pkg::POLY32 : 32'h00000000);
			assign n16 = {stage[i][14:0], 1'b0} ^ (fb16 ? bcrcg_pkg::POLY16 : 16'h0000);
			assign stage[i + 1] = use32 ? n32 : {16'h0000, n16};
		end
	endgenerate

	assign crc_out = stage[8];
endmodule : bcrcg_step

// ===== logic/bcrcg_top.sv
//Contract
// - 32-bit result reads reversed and inverted
// - CPU path polynomial selectable, default 16-bit
// - flash source forces 32-bit polynomial
// - engine works on whole bytes only
// - flash scopes: whole, application, boot, range
// - memory controller sets range, starts, returns result
// - every byte written with the I/O source selected and no flash run active updates the checksum
// - one new byte accepted every cycle
// - busy held until done, result in data
// - whole-flash command ignores lock bits
// - whole-flash run disconnects link, clears enable
module bcrcg_top #(
	parameter logic [15:0] FLASH_END = 16'hffff,
	parameter logic [15:0] APP_END = 16'hdfff,
	parameter logic [15:0] BOOT_START = 16'he000
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic EXT_MASTER,
	output logic [7:0] RDATA,
	// flash read port
	output logic [15:0] FLASH_ADDR,
	output logic FLASH_RD,
	input wire logic [7:0] FLASH_RDATA,
	// lock and link status
	input wire logic LOCK_READ,
	output logic PATH_EN,
	output logic MEM_BUSY
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] ctrl, next_ctrl;
	logic io_busy, next_io_busy;
	logic [31:0] checksum, next_checksum;
	logic [7:0] cmd, next_cmd;
	logic [15:0] range_start, next_range_start;
	logic [15:0] range_end, next_range_end;
	logic [31:0] mem_data, next_mem_data;
	logic [2:0] unlock_cnt, next_unlock_cnt;
	logic [7:0] next_rdata;
	bcrcg_pkg::bcrcg_state_e state, next_state;
	logic [15:0] cur, next_cur;
	logic [15:0] stop, next_stop;
	logic rd_pend, next_rd_pend;
	logic whole_run, next_whole_run;
	logic [15:0] next_flash_addr;
	logic next_flash_rd;
	logic next_path_en;
	logic next_mem_busy;

	logic [1:0] src;
	logic use32;
	logic link_wr_ok;
	logic exec_req;
	logic start_ok;
	logic [15:0] scope_lo, scope_hi;
	logic feed;
	logic [7:0] feed_byte;
	logic [31:0] stepped;
	logic [31:0] shown;

	assign src = ctrl[bcrcg_pkg::CTRL_SRC_LSB +: 2];
	// flash source overrides the selection bit
	assign use32 = ctrl[bcrcg_pkg::CTRL_POLY32_BIT] || (src == bcrcg_pkg::SRC_FLASH);

	function automatic logic [31:0] bitrev32(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h00000000;
		for (int k = 0; k < 32; k++) begin
			r[k] = v[31 - k];
		end
		return r;
	endfunction : bitrev32

	// read view of the running value, never a snapshot
	assign shown = use32 ? ~bitrev32(checksum) : {16'h0000, checksum[15:0]};

	// link writes dropped while it is cut off
	assign link_wr_ok = WR && !(EXT_MASTER && !PATH_EN);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_comb begin
		scope_lo = 16'h0000;
		scope_hi = FLASH_END;
		start_ok = 1'b0;
		case (cmd)
			bcrcg_pkg::CMD_FLASH_CRC: begin
				start_ok = 1'b1;
			end
			bcrcg_pkg::CMD_APP_CRC: begin
				scope_hi = APP_END;
				start_ok = !LOCK_READ;
			end
			bcrcg_pkg::CMD_BOOT_CRC: begin
				scope_lo = BOOT_START;
				start_ok = !LOCK_READ;
			end
			bcrcg_pkg::CMD_RANGE_CRC: begin
				scope_lo = range_start;
				scope_hi = range_end;
				start_ok = !LOCK_READ;
			end
			default: begin
				start_ok = 1'b0;
			end
		endcase
	end

	// cpu writes need the unlock window; the programmer link does not
	assign exec_req = link_wr_ok && (ADDR == bcrcg_pkg::OFF_MEMCTL_CONTROL_A)
		&& WDATA[bcrcg_pkg::CONTROL_A_EXEC_BIT] && (EXT_MASTER || (unlock_cnt != 3'h0))
		&& (state == bcrcg_pkg::ST_IDLE) && (src == bcrcg_pkg::SRC_FLASH) && start_ok;

	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	assign feed = rd_pend || (link_wr_ok && (ADDR == bcrcg_pkg::OFF_CRC_BYTE_INPUT)
		&& (src == bcrcg_pkg::SRC_IO) && (state == bcrcg_pkg::ST_IDLE));
	assign feed_byte = rd_pend ? FLASH_RDATA : WDATA;

	bcrcg_step u_step (
		.crc_in(checksum),
		.data(feed_byte),
		.use32(use32),
		.crc_out(stepped)
	);

	// ----------------------------------------
	// flash sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_stop = stop;
		next_rd_pend = FLASH_RD;
		next_whole_run = whole_run;
		next_flash_addr = FLASH_ADDR;
		next_flash_rd = 1'b0;
		next_path_en = PATH_EN;
		next_mem_busy = MEM_BUSY;
		case (state)
			bcrcg_pkg::ST_IDLE: begin
				if (exec_req) begin
					next_mem_busy = 1'b1;
					next_cur = scope_lo;
					next_stop = scope_hi;
					next_whole_run = (cmd == bcrcg_pkg::CMD_FLASH_CRC);
					if (cmd == bcrcg_pkg::CMD_FLASH_CRC) begin
						next_path_en = 1'b0;
					end
					// an empty range still completes
					next_state = (scope_lo > scope_hi) ? bcrcg_pkg::ST_LAST : bcrcg_pkg::ST_RUN;
				end
			end
			bcrcg_pkg::ST_RUN: begin
				next_flash_rd = 1'b1;
				next_flash_addr = cur;
				next_cur = 16'(cur + 16'h0001);
				if (cur == stop) begin
					next_state = bcrcg_pkg::ST_LAST;
				end
			end
			bcrcg_pkg::ST_LAST: begin
				// wait for the final byte still in flight
				if (!FLASH_RD && !rd_pend) begin
					next_state = bcrcg_pkg::ST_DONE;
				end
			end
			bcrcg_pkg::ST_DONE: begin
				next_mem_busy = 1'b0;
				next_path_en = 1'b1;
				next_whole_run = 1'b0;
				next_state = bcrcg_pkg::ST_IDLE;
			end
			default: begin
				next_state = bcrcg_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			state <= bcrcg_pkg::ST_IDLE;
			cur <= 16'h0000;
			stop <= 16'h0000;
			rd_pend <= 1'b0;
			whole_run <= 1'b0;
			FLASH_ADDR <= 16'h0000;
			FLASH_RD <= 1'b0;
			PATH_EN <= 1'b1;
			MEM_BUSY <= 1'b0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			stop <= next_stop;
			rd_pend <= next_rd_pend;
			whole_run <= next_whole_run;
			FLASH_ADDR <= next_flash_addr;
			FLASH_RD <= next_flash_rd;
			PATH_EN <= next_path_en;
			MEM_BUSY <= next_mem_busy;
		end
	end

	// ----------------------------------------
	// registers and checksum
	// ----------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_io_busy = io_busy;
		next_checksum = checksum;
		next_cmd = cmd;
		next_range_start = range_start;
		next_range_end = range_end;
		next_mem_data = mem_data;
		next_unlock_cnt = (unlock_cnt != 3'h0) ? 3'(unlock_cnt - 3'h1) : 3'h0;
		next_rdata = 8'h00;
		if (link_wr_ok) begin
			case (ADDR)
				bcrcg_pkg::OFF_CRC_CTRL: begin
					next_ctrl = WDATA & ~(8'h01 << bcrcg_pkg::CTRL_CLEAR_BIT);
					if (WDATA[bcrcg_pkg::CTRL_CLEAR_BIT]) begin
						next_checksum = (WDATA[bcrcg_pkg::CTRL_POLY32_BIT]
							|| (WDATA[bcrcg_pkg::CTRL_SRC_LSB +: 2] == bcrcg_pkg::SRC_FLASH))
							? bcrcg_pkg::INIT32 : bcrcg_pkg::INIT16;
					end
				end
				bcrcg_pkg::OFF_CRC_STATUS: begin
					if (WDATA[bcrcg_pkg::STATUS_BUSY_BIT]) begin
						next_io_busy = 1'b0;
					end
				end
				bcrcg_pkg::OFF_MEMCTL_CMD: next_cmd = WDATA;
				bcrcg_pkg::OFF_RANGE_START_L: next_range_start[7:0] = WDATA;
				bcrcg_pkg::OFF_RANGE_START_H: next_range_start[15:8] = WDATA;
				bcrcg_pkg::OFF_RANGE_END_L: next_range_end[7:0] = WDATA;
				bcrcg_pkg::OFF_RANGE_END_H: next_range_end[15:8] = WDATA;
				bcrcg_pkg::OFF_CHANGE_PROTECT_UNLOCK: begin
					if (!EXT_MASTER && (WDATA == bcrcg_pkg::UNLOCK_KEY)) begin
						next_unlock_cnt = bcrcg_pkg::UNLOCK_CYCLES;
					end
				end
				default: begin
				end
			endcase
		end
		// a flash run always starts from the 32-bit seed
		if (exec_req) begin
			next_checksum = bcrcg_pkg::INIT32;
		end
		if (feed) begin
			next_checksum = stepped;
			if (!rd_pend) begin
				next_io_busy = 1'b1; // set beats a same-cycle clear
			end
		end
		if (state == bcrcg_pkg::ST_DONE) begin
			next_mem_data = shown;
		end
		if (RD) begin
			case (ADDR)
				bcrcg_pkg::OFF_CRC_CTRL: next_rdata = ctrl;
				bcrcg_pkg::OFF_CRC_STATUS: next_rdata = {7'h00, io_busy || MEM_BUSY};
				bcrcg_pkg::OFF_MEMCTL_CMD: next_rdata = cmd;
				bcrcg_pkg::OFF_MEMCTL_STATUS: next_rdata = {MEM_BUSY, 7'h00};
				bcrcg_pkg::OFF_RANGE_START_L: next_rdata = range_start[7:0];
				bcrcg_pkg::OFF_RANGE_START_H: next_rdata = range_start[15:8];
				bcrcg_pkg::OFF_RANGE_END_L: next_rdata = range_end[7:0];
				bcrcg_pkg::OFF_RANGE_END_H: next_rdata = range_end[15:8];
				bcrcg_pkg::OFF_LINK_STATUS: next_rdata = {6'h00, PATH_EN, 1'b0};
				default: begin
					if (ADDR >= bcrcg_pkg::OFF_CHECKSUM0 && ADDR <= bcrcg_pkg::OFF_CHECKSUM3) begin
						next_rdata = shown[8 * ADDR[1:0] +: 8];
					end else if (ADDR >= bcrcg_pkg::OFF_MEMCTL_DATA0 && ADDR <= bcrcg_pkg::OFF_MEMCTL_DATA3) begin
						next_rdata = mem_data[8 * ADDR[1:0] +: 8];
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			ctrl <= bcrcg_pkg::RST_CTRL;
			io_busy <= 1'b0;
			checksum <= bcrcg_pkg::INIT16;
			cmd <= bcrcg_pkg::RST_CMD;
			range_start <= bcrcg_pkg::RST_RANGE;
			range_end <= bcrcg_pkg::RST_RANGE;
			mem_data <= 32'h00000000;
			unlock_cnt <= 3'h0;
			RDATA <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			io_busy <= next_io_busy;
			checksum <= next_checksum;
			cmd <= next_cmd;
			range_start <= next_range_start;
			range_end <= next_range_end;
			mem_data <= next_mem_data;
			unlock_cnt <= next_unlock_cnt;
			RDATA <= next_rdata;
		end
	end
endmodule : bcrcg_top

// ===== sim/bcrcg_flash_model.sv
module bcrcg_flash_model (
	// clock
	input wire logic clk,
	// read request
	input wire logic [15:0] addr,
	input wire logic rd,
	// read answer
	output logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rdata = 8'h00;
	// idle line shows the inverse so a stale byte never passes
	always @(posedge clk) begin
		if (rd) begin
			rdata <= addr[7:0] * 8'h1d ^ 8'h5a;
		end else begin
			rdata <= ~rdata;
		end
	end
endmodule : bcrcg_flash_model

// ===== sim/bcrcg_sva.sv
module bcrcg_sva (
	// watched ports
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [15:0] FLASH_ADDR,
	input wire logic FLASH_RD,
	input wire logic PATH_EN,
	input wire logic MEM_BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	a_read_in_busy: assert property (FLASH_RD |-> MEM_BUSY)
		else $error("flash read outside busy");
	a_first_read: assert property ($rose(MEM_BUSY) |=> FLASH_RD)
		else $error("no flash read after start");
	a_addr_step: assert property (FLASH_RD && $past(FLASH_RD) |-> FLASH_ADDR == $past(FLASH_ADDR) + 16'h0001)
		else $error("flash address not ascending");
	a_path_off_busy: assert property (!PATH_EN |-> MEM_BUSY)
		else $error("link path off while idle");
	a_path_restore: assert property ($fell(MEM_BUSY) |-> PATH_EN)
		else $error("link path not restored");
	a_busy_hold: assert property ($rose(MEM_BUSY) |-> MEM_BUSY [*3])
		else $error("busy dropped early");
	a_busy_bound: assert property ($rose(MEM_BUSY) |-> ##[1:300] !MEM_BUSY)
		else $error("busy never ends");
	a_done_tail: assert property ($fell(FLASH_RD) |-> MEM_BUSY ##[1:5] !MEM_BUSY)
		else $error("busy tail wrong");
	c_flash_run: cover property ($rose(MEM_BUSY));
	c_whole_run: cover property ($fell(PATH_EN));
	c_read_data: cover property (RD ##1 RDATA != 8'h00);
endmodule : bcrcg_sva

bind bcrcg_top bcrcg_sva u_sva (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .RD(RD), .RDATA(RDATA),
	.FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD), .PATH_EN(PATH_EN), .MEM_BUSY(MEM_BUSY));

// ===== sim/bcrcg_tb_top.sv
module bcrcg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] FEND = 16'h001f;
	localparam logic [15:0] AEND = 16'h000f;
	localparam logic [15:0] BSTART = 16'h0010;
	logic CORE_CLK, RSTN, WR, RD, EXT_MASTER, LOCK_READ, FLASH_RD, PATH_EN, MEM_BUSY;
	logic [7:0] ADDR, WDATA, RDATA, FLASH_RDATA, b8;
	logic [15:0] FLASH_ADDR;
	logic [31:0] v;
	int miscompares, samples_checked, cycles, seed;
	byte unsigned bq[$];

	bcrcg_top #(.FLASH_END(FEND), .APP_END(AEND), .BOOT_START(BSTART)) uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .EXT_MASTER(EXT_MASTER), .RDATA(RDATA),
		.FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD), .FLASH_RDATA(FLASH_RDATA), .LOCK_READ(LOCK_READ),
		.PATH_EN(PATH_EN), .MEM_BUSY(MEM_BUSY));
	bcrcg_flash_model u_flash (.clk(CORE_CLK), .addr(FLASH_ADDR), .rd(FLASH_RD), .rdata(FLASH_RDATA));

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic logic [31:0] model(input bit w32);
		bit [31:0] c;
		c = w32 ? 32'hffffffff : 32'h0000ffff;
		foreach (bq[i]) begin
			if (w32) begin
				c ^= bq[i];
				repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
			end else begin
				c ^= {bq[i], 8'h00};
				repeat (8) c = (c[15] ? (c << 1) ^ 32'h1021 : c << 1) & 32'h0000ffff;
			end
		end
		return w32 ? ~c : c;
	endfunction : model

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		@(negedge CORE_CLK);
		d = RDATA;
	endtask : rd

	task automatic rd32(input logic [7:0] a, output logic [31:0] r);
		logic [7:0] b;
		for (int i = 0; i < 4; i++) begin
			rd(a + 8'(i), b);
			r[8*i +: 8] = b;
		end
	endtask : rd32

	// back-to-back bytes, one per cycle
	task automatic feed(input int n);
		byte unsigned b;
		for (int i = 0; i < n; i++) begin
			@(posedge CORE_CLK);
			b = 8'($random(seed));
			ADDR <= bcrcg_pkg::OFF_CRC_BYTE_INPUT;
			WDATA <= b;
			WR <= 1'b1;
			bq.push_back(b);
		end
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask : feed

	task automatic frun(input logic [7:0] cmd, input logic [15:0] lo, input logic [15:0] hi);
		int n;
		wr(bcrcg_pkg::OFF_MEMCTL_CMD, cmd);
		if (EXT_MASTER === 1'b0) wr(bcrcg_pkg::OFF_CHANGE_PROTECT_UNLOCK, bcrcg_pkg::UNLOCK_KEY);
		wr(bcrcg_pkg::OFF_MEMCTL_CONTROL_A, 8'h01);
		@(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk(MEM_BUSY, 1'b1);
		rd(bcrcg_pkg::OFF_MEMCTL_STATUS, b8);
		chk(b8[7], 1'b1);
		if (cmd == bcrcg_pkg::CMD_FLASH_CRC) begin
			chk(PATH_EN, 1'b0);
			rd(bcrcg_pkg::OFF_LINK_STATUS, b8);
			chk(b8[1], 1'b0);
			// link write while cut off must be dropped
			wr(bcrcg_pkg::OFF_RANGE_END_H, 8'h5a);
		end
		for (n = 0; n < 200 && MEM_BUSY !== 1'b0; n++) @(negedge CORE_CLK);
		chk(MEM_BUSY, 1'b0);
		chk(PATH_EN, 1'b1);
		if (cmd == bcrcg_pkg::CMD_FLASH_CRC) begin
			rd(bcrcg_pkg::OFF_RANGE_END_H, b8);
			chk(b8, 8'h00);
		end
		bq.delete();
		for (int a = lo; a <= hi; a++) bq.push_back(8'(a) * 8'h1d ^ 8'h5a);
		rd32(bcrcg_pkg::OFF_MEMCTL_DATA0, v);
		chk(v, model(1));
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, model(1));
	endtask : frun

	task automatic close_out;
		$display("checked=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------
	// clock, timeout, sequence
	// ----------------------------------------
	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end

	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end

	initial begin
		seed = 60;
		{RSTN, WR, RD, EXT_MASTER, LOCK_READ, ADDR, WDATA} = '0;
		repeat (2) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, 32'h0000ffff);
		rd(8'h02, b8);
		chk(b8, 8'h00);
		rd(bcrcg_pkg::OFF_LINK_STATUS, b8);
		chk(b8[1], 1'b1);
		wr(bcrcg_pkg::OFF_CRC_CTRL, {6'h00, bcrcg_pkg::SRC_IO});
		feed(9);
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, model(0));
		rd(bcrcg_pkg::OFF_CRC_STATUS, b8);
		chk(b8[0], 1'b1);
		wr(bcrcg_pkg::OFF_CRC_STATUS, 8'h01);
		rd(bcrcg_pkg::OFF_CRC_STATUS, b8);
		chk(b8[0], 1'b0);
		feed(3);
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, model(0));
		wr(bcrcg_pkg::OFF_CRC_CTRL, 8'h21);
		wr(bcrcg_pkg::OFF_CRC_CTRL, 8'ha1);
		bq.delete();
		feed(9);
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, model(1));
		feed(1);
		rd32(bcrcg_pkg::OFF_CHECKSUM0, v);
		chk(v, model(1));
		wr(bcrcg_pkg::OFF_CRC_CTRL, {6'h00, bcrcg_pkg::SRC_FLASH});
		wr(bcrcg_pkg::OFF_RANGE_START_L, 8'h05);
		wr(bcrcg_pkg::OFF_RANGE_END_L, 8'h12);
		EXT_MASTER <= 1'b1;
		frun(bcrcg_pkg::CMD_APP_CRC, 16'h0000, AEND);
		frun(bcrcg_pkg::CMD_BOOT_CRC, BSTART, FEND);
		frun(bcrcg_pkg::CMD_RANGE_CRC, 16'h0005, 16'h0012);
		@(posedge CORE_CLK);
		LOCK_READ <= 1'b1;
		frun(bcrcg_pkg::CMD_FLASH_CRC, 16'h0000, FEND);
		// lock still blocks a section command
		wr(bcrcg_pkg::OFF_MEMCTL_CMD, bcrcg_pkg::CMD_APP_CRC);
		wr(bcrcg_pkg::OFF_MEMCTL_CONTROL_A, 8'h01);
		repeat (3) @(negedge CORE_CLK);
		chk(MEM_BUSY, 1'b0);
		@(posedge CORE_CLK);
		LOCK_READ <= 1'b0;
		EXT_MASTER <= 1'b0;
		wr(bcrcg_pkg::OFF_MEMCTL_CONTROL_A, 8'h01);
		repeat (3) @(negedge CORE_CLK);
		chk(MEM_BUSY, 1'b0);
		frun(bcrcg_pkg::CMD_BOOT_CRC, BSTART, FEND);
		close_out();
	end
endmodule : bcrcg_tb_top
